// [include/cfdl_pkg.sv]
package cfdl_pkg;

    // -------------------------------------------------------------------------
    // Geometry of the block and of the serial frame
    // -------------------------------------------------------------------------
    localparam int         NUM_CH         = 5;
    localparam int         FRAME_BITS     = 8;

    // -------------------------------------------------------------------------
    // Command decode: bits 7:4 of a received frame select the target
    // -------------------------------------------------------------------------
    localparam logic [3:0] HARDWARE_CONFIG_COMMAND_PREFIX    = 4'hC;
    localparam logic [3:0] DCR_PREFIX     = 4'hD;
    localparam int         CTL_POS        = 0;
    localparam int         SEL_LSB        = 0;
    localparam int         SEL_WIDTH      = 3;

    // -------------------------------------------------------------------------
    // Sense multiplexer codes and reset values
    // -------------------------------------------------------------------------
    localparam logic [2:0] SEL_DISABLE    = 3'h6;
    localparam logic [2:0] SEL_RESET      = 3'h6;
    localparam logic [4:0] FLAGS_RESET    = 5'h00;
    localparam logic [7:0] WORD_RESET     = 8'h00;

    // -------------------------------------------------------------------------
    // Diagnosis word layout and serial clock edge positions
    // -------------------------------------------------------------------------
    localparam int         SBM_POS        = 7;
    localparam logic [3:0] OVL_CLEAR_EDGE = 4'h2;
    localparam logic [3:0] REARM_EDGE     = 4'h3;
    localparam logic [3:0] FULL_FRAME     = 4'h8;

    // -------------------------------------------------------------------------
    // Grouped signals
    // -------------------------------------------------------------------------
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic mosi;
    } cfdl_spi_type;

    typedef struct packed {
        logic [4:0] overload;
        logic [4:0] overtemp;
        logic [4:0] vds_low;
    } cfdl_chan_type;

endpackage

// [sim/cfdl_spi_host.sv]
module cfdl_spi_host (
    input  wire logic              clk,
    output cfdl_pkg::cfdl_spi_type spi,
    input  wire logic              miso
);
    timeunit 1ns;
    timeprecision 100ps;

    // --------------------------------------------------------------------
    // Serial host model
    // --------------------------------------------------------------------

    // Idle bus: frame deselected and the serial clock parked low.
    initial begin
        spi = '{cs_n: 1'b1, sclk: 1'b0, mosi: 1'b0};
    end

    // One 8-bit frame, MSB first, with a 125 ns serial period.
    // The word coming back is sampled at each rising serial edge.
    // Starting 1 ns after a clock edge keeps every serial edge clear of a sampling edge.
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        @(posedge clk);
        #1;
        spi.cs_n = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            spi.mosi = tx[i];
            #62.5;
            spi.sclk = 1'b1;
            rx[i] = miso;
            #62.5;
            spi.sclk = 1'b0;
        end
        #62.5;
        spi.cs_n = 1'b1;
        // The released data line toggles so a stale bit never looks valid.
        spi.mosi = ~spi.mosi;
        #100;
    endtask
endmodule

// [sim/channel_fault_diagnosis_latch_bench.sv]
module channel_fault_diagnosis_latch_bench;
    timeunit 1ns;
    timeprecision 100ps;

    logic                    clk = 1'b0;
    logic                    rst = 1'b1;
    cfdl_pkg::cfdl_spi_type  spi;
    cfdl_pkg::cfdl_chan_type chan = '0;
    logic [4:0]              on = 5'h00;
    logic [4:0]              therm = 5'h00;
    logic [4:0]              gate;
    logic [4:0]              route;
    logic                    miso;
    logic                    miso_oe;
    logic                    ce = 1'b1;
    logic                    sense_oe;
    logic                    sbm;
    logic [2:0]              sel;
    logic [2:0]              sel_m = 3'h6;
    logic [7:0]              rx;
    int                      fails = 0;
    int                      n_tests = 0;
    int                      k;

    // --------------------------------------------------------------------
    // Design, host model and clock
    // --------------------------------------------------------------------
    cfdl_fault_latch i_cfdl_fault_latch (
        .clk(clk), .rst(rst), .ce(ce), .spi(spi), .spi_miso(miso),
        .spi_miso_oe(miso_oe), .chan(chan), .channel_on_request(on),
        .gate_enable(gate), .sense_route(route), .sense_output_pin_oe(sense_oe),
        .bypass_monitor_result(sbm), .sense_channel_select(sel)
    );

    cfdl_spi_host i_cfdl_spi_host (.clk(clk), .spi(spi), .miso(miso));

    // A 100 MHz clock.
    always #5 clk = ~clk;

    // --------------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        if (fails == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Codes 5 to 7 route nothing, so they expect an empty one-hot.
    function automatic logic [4:0] route_exp();
        return (sel_m < 3'h5) ? 5'h01 << sel_m : 5'h00;
    endfunction

    function automatic logic [7:0] word(input logic [4:0] flt);
        return {|(route_exp() & chan.vds_low), 2'b00, flt};
    endfunction

    task automatic outs();
        #1;
        check("route", 8'(route), 8'(route_exp()));
        check("sense_oe", 8'(sense_oe), 8'(|(route_exp() & on & ~chan.overload & ~therm)));
        check("bypass", 8'(sbm), 8'(|(route_exp() & chan.vds_low)));
        check("gate", 8'(gate), 8'(on & ~therm));
        check("miso_oe", 8'(miso_oe), 8'h00);
    endtask

    // A frame with an unknown prefix is a plain diagnosis readout.
    task automatic diag(input logic [4:0] flt);
        i_cfdl_spi_host.xfer(8'h00, rx);
        check("diag", rx, word(flt));
    endtask

    // --------------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------------
    initial begin
        void'($urandom(51088));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        outs();
        check("select", 8'(sel), 8'(cfdl_pkg::SEL_RESET));
        // A low enable freezes every register, so a new on request stays unseen.
        @(posedge clk);
        ce <= 1'b0;
        on <= 5'h1F;
        repeat (4) @(posedge clk);
        #1;
        check("frozen gate", 8'(gate), 8'h00);
        @(posedge clk);
        ce <= 1'b1;
        // Every select code with random on requests and comparator levels.
        for (int c = 0; c < 8; c++) begin
            @(posedge clk);
            on <= 5'($urandom);
            chan.vds_low <= 5'($urandom);
            i_cfdl_spi_host.xfer({cfdl_pkg::DCR_PREFIX, 1'b0, 3'(c)}, rx);
            sel_m = 3'(c);
            check("select", 8'(sel), 8'(sel_m));
            outs();
        end
        // Park the select on channel 0 so each diagnosis word carries a live bypass bit.
        @(posedge clk);
        chan.vds_low <= 5'h01 | 5'($urandom);
        i_cfdl_spi_host.xfer({cfdl_pkg::DCR_PREFIX, 4'h0}, rx);
        sel_m = 3'h0;
        outs();
        // Overload pulses clear after one readout; a lasting one persists.
        for (int n = 0; n < 3; n++) begin
            k = (n == 0) ? 4 : $urandom_range(0, 4);
            @(posedge clk);
            on <= 5'h1F;
            chan.overload[k] <= 1'b1;
            repeat (10) @(posedge clk);
            chan.overload[k] <= (n == 2);
            repeat (5) @(posedge clk);
            diag(5'h01 << k);
            diag((n == 2) ? 5'h01 << k : 5'h00);
        end
        @(posedge clk);
        chan.overload <= 5'h00;
        diag(5'h01 << k);
        diag(5'h00);
        // Thermal event on an off channel latches and survives readouts.
        k = $urandom_range(0, 4);
        @(posedge clk);
        on <= ~(5'h01 << k);
        chan.overtemp[k] <= 1'b1;
        repeat (6) @(posedge clk);
        chan.overtemp[k] <= 1'b0;
        on <= 5'h1F;
        therm[k] = 1'b1;
        repeat (6) @(posedge clk);
        outs();
        diag(therm);
        diag(therm);
        i_cfdl_spi_host.xfer({cfdl_pkg::HARDWARE_CONFIG_COMMAND_PREFIX, 4'h2}, rx);
        outs();
        i_cfdl_spi_host.xfer({cfdl_pkg::HARDWARE_CONFIG_COMMAND_PREFIX, 4'h1}, rx);
        therm = 5'h00;
        outs();
        diag(5'h01 << k);
        diag(5'h00);
        close_out();
    end

    // A hung handshake ends the run after about ten times the expected span.
    initial begin
        #300us;
        fails++;
        close_out();
    end
endmodule

// [src/cfdl_fault_latch.sv]
module cfdl_fault_latch (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   ce,
    input  wire cfdl_pkg::cfdl_spi_type spi,
    output logic                        spi_miso,
    output logic                        spi_miso_oe,
    input  wire cfdl_pkg::cfdl_chan_type chan,
    input  wire logic [4:0]             channel_on_request,
    output logic [4:0]                  gate_enable,
    output logic [4:0]                  sense_route,
    output logic                        sense_output_pin_oe,
    output logic                        bypass_monitor_result,
    output logic [2:0]                  sense_channel_select
);

    // -------------------------------------------------------------------------
    // Input synchronisers
    // -------------------------------------------------------------------------
    cfdl_pkg::cfdl_spi_type  spi_m, spi_s, spi_d;
    cfdl_pkg::cfdl_chan_type chan_m, chan_s;

    // Two stages for the serial and channel inputs, plus a third serial stage spi_d for edge detection; channel_on_request is not synchronised.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            spi_m  <= '{cs_n: 1'b1, sclk: 1'b0, mosi: 1'b0};
            spi_s  <= '{cs_n: 1'b1, sclk: 1'b0, mosi: 1'b0};
            spi_d  <= '{cs_n: 1'b1, sclk: 1'b0, mosi: 1'b0};
            chan_m <= '0;
            chan_s <= '0;
        end else if (ce) begin
            spi_m  <= spi;
            spi_s  <= spi_m;
            spi_d  <= spi_s;
            chan_m <= chan;
            chan_s <= chan_m;
        end
    end

    // -------------------------------------------------------------------------
    // Frame events
    // -------------------------------------------------------------------------
    logic       frame_start, frame_end, in_frame, rise, fall;
    logic [3:0] rise_cnt, rise_num;
    logic       clear_ovl, ctl_clear, ctl_pending;
    logic [7:0] rx, tx;
    logic [4:0] ovl_latch, therm_latch, therm_err, fault;

    // Events are gated by ce so that a frozen block sees nothing.
    assign in_frame    = !spi_s.cs_n;
    assign frame_start = ce && spi_d.cs_n && !spi_s.cs_n;
    assign frame_end   = ce && !spi_d.cs_n && spi_s.cs_n;
    assign rise        = ce && in_frame && spi_s.sclk && !spi_d.sclk;
    assign fall        = ce && in_frame && !spi_s.sclk && spi_d.sclk;
    assign rise_num    = rise_cnt + 4'h1;
    assign clear_ovl   = rise && (rise_num == cfdl_pkg::OVL_CLEAR_EDGE);
    assign ctl_clear   = frame_end && (rise_cnt == cfdl_pkg::FULL_FRAME) &&
                         (rx[7:4] == cfdl_pkg::HARDWARE_CONFIG_COMMAND_PREFIX) && rx[cfdl_pkg::CTL_POS];
    assign fault       = therm_err | ovl_latch;

    // Counts rising serial clock edges within the current frame.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rise_cnt <= 4'h0;
        end else if (frame_start) begin
            rise_cnt <= 4'h0;
        end else if (rise && rise_cnt != 4'hF) begin
            rise_cnt <= rise_num;
        end
    end

    // Receive shift register, sampled on rising serial clock edges.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx <= cfdl_pkg::WORD_RESET;
        end else if (rise) begin
            rx <= {rx[6:0], spi_s.mosi};
        end
    end

    // Transmit: the diagnosis word is snapshotted at frame start, so the flags
    // shown are exactly those latched before any in-frame clearing.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx <= cfdl_pkg::WORD_RESET;
        end else if (frame_start) begin
            tx <= {bypass_monitor_result, 2'b00, fault};
        end else if (fall) begin
            tx <= {tx[6:0], 1'b0};
        end
    end

    assign spi_miso    = tx[7];
    assign spi_miso_oe = in_frame;

    // -------------------------------------------------------------------------
    // Diagnosis control: sense channel select
    // -------------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sense_channel_select <= cfdl_pkg::SEL_RESET;
        end else if (frame_end && rise_cnt == cfdl_pkg::FULL_FRAME &&
                     rx[7:4] == cfdl_pkg::DCR_PREFIX) begin
            sense_channel_select <= rx[cfdl_pkg::SEL_LSB +: cfdl_pkg::SEL_WIDTH];
        end
    end

    // A clear command freezes the error copy until the next frame, then holds it down through
    // that frame's third rising edge; the freeze is why one stale diagnosis follows it.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctl_pending <= 1'b0;
        end else if (ctl_clear) begin
            ctl_pending <= 1'b1;
        end else if (rise && rise_num == cfdl_pkg::REARM_EDGE) begin
            ctl_pending <= 1'b0;
        end
    end

    // -------------------------------------------------------------------------
    // Per-channel latches; a set wins over a clear in the same cycle, except in therm_err where the clear wins
    // -------------------------------------------------------------------------
    for (genvar i = 0; i < cfdl_pkg::NUM_CH; i++) begin : g_ch
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                ovl_latch[i]   <= 1'b0;
                therm_latch[i] <= 1'b0;
                therm_err[i]   <= 1'b0;
                gate_enable[i] <= 1'b0;
            end else if (ce) begin
                if (chan_s.overload[i]) begin
                    ovl_latch[i] <= 1'b1;
                end else if (clear_ovl) begin
                    ovl_latch[i] <= 1'b0;
                end
                if (chan_s.overtemp[i]) begin
                    therm_latch[i] <= 1'b1;
                end else if (ctl_clear) begin
                    therm_latch[i] <= 1'b0;
                end
                if (ctl_pending && in_frame) begin
                    therm_err[i] <= 1'b0;
                end else if (therm_latch[i] && !ctl_pending) begin
                    therm_err[i] <= 1'b1;
                end
                gate_enable[i] <= channel_on_request[i] && !therm_latch[i] &&
                                  !chan_s.overtemp[i];
            end
        end
    end

    // -------------------------------------------------------------------------
    // Sense multiplexer and bypass monitor
    // -------------------------------------------------------------------------
    logic       sel_valid;
    logic [2:0] sel;

    assign sel       = sense_channel_select;
    assign sel_valid = (sel < 3'h5);

    // Codes 5 and 7 are treated like the disable code: nothing is routed.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sense_route           <= 5'h00;
            sense_output_pin_oe   <= 1'b0;
            bypass_monitor_result <= 1'b0;
        end else if (ce) begin
            sense_route           <= sel_valid ? 5'(5'h01 << sel) : 5'h00;
            sense_output_pin_oe   <= sel_valid && channel_on_request[sel] &&
                                     !chan_s.overload[sel] && !chan_s.overtemp[sel] &&
                                     !therm_latch[sel];
            bypass_monitor_result <= sel_valid && chan_s.vds_low[sel];
        end
    end

    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    diag_snapshot_a: assert property (frame_start |=> tx[4:0] == $past(fault))
        else $error("Diagnosis word does not carry the error flags.");
    ovl_clear_a: assert property (clear_ovl |=> (ovl_latch & ~$past(chan_s.overload)) == 5'h00)
        else $error("Overload flag survived the second serial clock edge.");
    gate_off_a: assert property (ce && |therm_latch |=> (gate_enable & $past(therm_latch)) == 5'h00)
        else $error("Gate enabled while its thermal latch is set.");
    therm_hold_a: assert property (|($past(therm_latch) & ~therm_latch) |-> $past(ctl_clear))
        else $error("Thermal latch cleared without a command.");
    ctl_all_a: assert property (ctl_clear |=> therm_latch == $past(chan_s.overtemp))
        else $error("Clear command did not clear every thermal latch.");
    rearm_hold_a: assert property (ce && ctl_pending && in_frame |=> therm_err == 5'h00)
        else $error("Thermal error copy not held clear after command.");
    ovl_reset_a: assert property (ce |=> (ovl_latch & $past(chan_s.overload)) == $past(chan_s.overload))
        else $error("Persisting overload did not set its flag.");
    ovl_keep_a: assert property (|($past(ovl_latch) & ~ovl_latch) |-> $past(clear_ovl))
        else $error("Overload flag lost before transmission.");
    sense_onehot_a: assert property (sense_output_pin_oe |-> $onehot(sense_route))
        else $error("Sense output enabled without a single routed channel.");
    sense_off_a: assert property (ce && sel == cfdl_pkg::SEL_DISABLE |=> !sense_output_pin_oe)
        else $error("Sense output enabled with disable code.");

    ctl_seen_c: cover property (ctl_clear ##[1:400] clear_ovl);
    ovl_seen_c: cover property (ovl_latch != 5'h00 ##1 clear_ovl);
    sense_seen_c: cover property (sense_output_pin_oe);

endmodule
